// ==== target_pin_test_driver.sv ====
// Pin test driver: control word to static connector levels, results and interrupt.
//
// Our own choices: the Wishbone slave port and the address map.
`timescale 1ns/1ps

// Functional notes
// - Word bits 2:0 pick one of eight target data channels, code 0 is channel 1.
// - Bit 0x0008 drives selected data line and shared data/fuse pin high; without it all data lines are low.
// - Bit 0x0010 sets TCK level.
// - Bit 0x0020 sets TMS level.
// - Bit 0x0040 sets test/fuse pin logic level.
// - Bit 0x0080 sets shared data/fuse pin logic level.
// - Bit 0x0100 switches the target supply output.
// - Bit 0x0200 puts fuse voltage on shared pin, overriding its logic level.
// - Bit 0x0400 puts fuse voltage on the test/fuse pin.
// - Pin levels hold unchanged until a new control word arrives.
// - End-of-check code returns all pins to initial state and clears control word and results; interrupt mask is kept.
// - Result byte has one success bit per channel, channel one in the LSB.
// - General error code reports 0, 1, 11 or 16.
// - Busy reads 1 during gang programming, 0 after, then results are readable.
// - Pins not selected or enabled stay at zero volts.
module target_pin_test_driver (
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    input  wire logic                   wb_cyc_i,
    input  wire logic                   wb_stb_i,
    input  wire logic                   wb_we_i,
    input  wire logic [3:0]             wb_adr_i,
    input  wire logic [3:0]             wb_sel_i,
    input  wire logic [31:0]            wb_dat_i,
    output logic      [31:0]            wb_dat_o,
    output logic                        wb_ack_o,
    input  wire logic                   gang_busy_i,
    input  wire logic [7:0]             channel_ok_i,
    input  wire logic [7:0]             error_code_i,
    output pin_test_pkg::pins_type      pins_o,
    output logic                        irq_o
);

    logic                              ack_q, ack_d;
    logic [31:0]                       rdata_q, rdata_d;
    logic [15:0]                       word_q, word_d;
    pin_test_pkg::pins_type            pins_q, pins_d;
    logic [7:0]                        result_q, result_d;
    logic [7:0]                        error_q, error_d;
    logic                              busy_q, busy_d;
    logic [pin_test_pkg::irq_width-1:0] stat_q, stat_d;
    logic [pin_test_pkg::irq_width-1:0] mask_q, mask_d;
    logic [pin_test_pkg::irq_width-1:0] events;
    logic                              req, wr, rd;
    logic                              word_wr, end_cmd, gang_done;
    logic [15:0]                       new_word;

    // Decodes a control word into connector levels.
    function automatic pin_test_pkg::pins_type decode(input logic [15:0] w);
        pin_test_pkg::pins_type p;
        logic [2:0]             sel;
        p = pin_test_pkg::pins_reset;
        sel = w[pin_test_pkg::sel_lsb +: pin_test_pkg::sel_width];
        if (w[pin_test_pkg::data_bit]) begin
            p.target_data_line = 8'h01 << sel;
        end
        p.fuse_vpp = w[pin_test_pkg::fuse_vpp_bit];
        // Fuse voltage on the shared pin takes it away from logic drive.
        p.fuse_level = ~w[pin_test_pkg::fuse_vpp_bit]
            & (w[pin_test_pkg::data_bit] | w[pin_test_pkg::fuse_lvl_bit]);
        p.tck = w[pin_test_pkg::tck_bit];
        p.tms = w[pin_test_pkg::tms_bit];
        p.test_level = w[pin_test_pkg::test_lvl_bit];
        p.target_supply_output = w[pin_test_pkg::supply_bit];
        p.test_vpp = w[pin_test_pkg::test_vpp_bit];
        return p;
    endfunction

    // Wishbone classic slave: one wait state, ack for one cycle.
    always_comb begin
        req = wb_cyc_i & wb_stb_i & ~ack_q;
        wr  = req & wb_we_i;
        rd  = req & ~wb_we_i;
        ack_d = req;
        rdata_d = rdata_q;
        if (rd) begin
            case (wb_adr_i)
                pin_test_pkg::ctrl_off: begin
                    rdata_d = {16'h0000, word_q};
                end
                pin_test_pkg::result_off: begin
                    rdata_d = {15'h0000, busy_q, error_q, result_q};
                end
                pin_test_pkg::irq_stat_off: begin
                    rdata_d = {29'h0, stat_q};
                end
                pin_test_pkg::irq_mask_off: begin
                    rdata_d = {29'h0, mask_q};
                end
                default: begin
                    rdata_d = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ack_q   <= ack_d;
            rdata_q <= rdata_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdata_q;

    // Control word and connector pins.
    always_comb begin
        new_word = word_q;
        if (wb_sel_i[0]) begin
            new_word[7:0] = wb_dat_i[7:0];
        end
        if (wb_sel_i[1]) begin
            new_word[15:8] = wb_dat_i[15:8];
        end
        word_wr = wr && (wb_adr_i == pin_test_pkg::ctrl_off) && (wb_sel_i[1:0] != 2'b00);
        end_cmd = word_wr && new_word[pin_test_pkg::end_bit];
        word_d = word_q;
        pins_d = pins_q;
        if (end_cmd) begin
            word_d = pin_test_pkg::ctrl_reset;
            pins_d = pin_test_pkg::pins_reset;
        end else if (word_wr) begin
            word_d = new_word;
            pins_d = decode(new_word);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            word_q <= pin_test_pkg::ctrl_reset;
            pins_q <= pin_test_pkg::pins_reset;
        end else begin
            word_q <= word_d;
            pins_q <= pins_d;
        end
    end

    assign pins_o = pins_q;

    // Gang programming status; results are captured when busy falls.
    always_comb begin
        busy_d    = gang_busy_i;
        gang_done = busy_q & ~gang_busy_i;
        result_d  = result_q;
        error_d   = error_q;
        // End-of-check wins over a capture in the same cycle: the session is torn down.
        if (end_cmd) begin
            result_d = 8'h00;
            error_d  = pin_test_pkg::err_none;
        end else if (gang_done) begin
            result_d = channel_ok_i;
            error_d  = error_code_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_q   <= 1'b0;
            result_q <= 8'h00;
            error_q  <= pin_test_pkg::err_none;
        end else begin
            busy_q   <= busy_d;
            result_q <= result_d;
            error_q  <= error_d;
        end
    end

    // Interrupts: sticky status, cleared by reading it; a new event wins over the clear.
    always_comb begin
        events = '0;
        events[pin_test_pkg::irq_word_bit] = word_wr & ~end_cmd;
        events[pin_test_pkg::irq_end_bit]  = end_cmd;
        events[pin_test_pkg::irq_done_bit] = gang_done;
        stat_d = stat_q;
        if (rd && (wb_adr_i == pin_test_pkg::irq_stat_off)) begin
            stat_d = '0;
        end
        stat_d = stat_d | events;
        mask_d = mask_q;
        if (wr && (wb_adr_i == pin_test_pkg::irq_mask_off) && wb_sel_i[0]) begin
            mask_d = wb_dat_i[pin_test_pkg::irq_width-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stat_q <= '0;
            mask_q <= '0;
        end else begin
            stat_q <= stat_d;
            mask_q <= mask_d;
        end
    end

    assign irq_o = |(stat_q & mask_q);

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    chk_channel_select: assert property (
        word_wr && !end_cmd && new_word[3]
        |=> pins_o.target_data_line == (8'h01 << $past(new_word[2:0])))
        else $error("selected data line does not match the channel code");

    chk_data_high: assert property (
        word_wr && !end_cmd && new_word[3] && !new_word[9]
        |=> pins_o.fuse_level && (pins_o.target_data_line != 8'h00))
        else $error("data bit did not raise data line and shared pin");

    chk_clock_mode: assert property (
        word_wr && !end_cmd
        |=> pins_o.tck == $past(new_word[4]) && pins_o.tms == $past(new_word[5]))
        else $error("clock or mode-select level wrong after a word");

    chk_supply_switch: assert property (
        word_wr && !end_cmd |=> pins_o.target_supply_output == $past(new_word[8]))
        else $error("supply output does not follow its bit");

    chk_fuse_override: assert property (
        pins_o.fuse_vpp |-> !pins_o.fuse_level)
        else $error("shared pin has logic drive while fuse voltage is on");

    chk_test_fuse: assert property (
        word_wr && !end_cmd
        |=> pins_o.test_vpp == $past(new_word[10]) && pins_o.test_level == $past(new_word[6]))
        else $error("test pin levels do not follow the word");

    chk_pins_hold: assert property (
        !word_wr |=> $stable(pins_o))
        else $error("pins changed without a new control word");

    chk_end_reinit: assert property (
        end_cmd |=> pins_o == pin_test_pkg::pins_reset && word_q == 16'h0000
        && result_q == 8'h00)
        else $error("end-of-check did not reinitialise");

    chk_result_capture: assert property (
        busy_q && !gang_busy_i && !end_cmd
        |=> result_q == $past(channel_ok_i) && error_q == $past(error_code_i))
        else $error("results not captured at end of operation");

    chk_idle_pins: assert property (
        !pins_q.fuse_vpp && !word_q[3] && !word_q[7] |-> !pins_o.fuse_level
        && pins_o.target_data_line == 8'h00)
        else $error("unselected pin is driven");

    chk_bus_ack: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus answer is not a single cycle after one wait state");

    chk_ack_idle: assert property (
        !wb_cyc_i |=> !wb_ack_o)
        else $error("bus answered with no cycle open");

    // Register side: what software reads back and what the status bits remember.
    chk_ctrl_readback: assert property (
        rd && wb_adr_i == pin_test_pkg::ctrl_off
        |=> wb_dat_o == {16'h0000, $past(word_q)})
        else $error("control word read back wrong");

    chk_busy_report: assert property (
        rd && wb_adr_i == pin_test_pkg::result_off
        |=> wb_dat_o[pin_test_pkg::busy_bit] == $past(gang_busy_i, 2))
        else $error("busy bit read back does not follow the engine");

    chk_error_report: assert property (
        rd && wb_adr_i == pin_test_pkg::result_off
        |=> wb_dat_o[pin_test_pkg::error_lsb +: 8] == $past(error_q))
        else $error("general error code read back wrong");

    chk_result_hold: assert property (
        !gang_done && !end_cmd |=> $stable(result_q) && $stable(error_q))
        else $error("results changed outside the end of an operation");

    chk_mask_write: assert property (
        wr && wb_adr_i == pin_test_pkg::irq_mask_off && wb_sel_i[0]
        |=> mask_q == $past(wb_dat_i[pin_test_pkg::irq_width-1:0]))
        else $error("mask register did not take the written value");

    chk_word_event: assert property (
        word_wr && !end_cmd |=> stat_q[pin_test_pkg::irq_word_bit])
        else $error("applied word did not set its status bit");

    // A clearing read must never swallow an event of the same cycle.
    chk_stat_sticky: assert property (
        gang_done |=> stat_q[pin_test_pkg::irq_done_bit])
        else $error("done event lost from the status register");

    chk_stat_clear: assert property (
        rd && wb_adr_i == pin_test_pkg::irq_stat_off && !gang_done |=> stat_q == '0)
        else $error("status read did not clear the status bits");

    chk_end_event: assert property (
        end_cmd |=> stat_q[pin_test_pkg::irq_end_bit] && mask_q == $past(mask_q))
        else $error("end-of-check lost its event or the mask");

    // Connector side: levels that the word must set and combinations it must never show.
    chk_shared_level: assert property (
        word_wr && !end_cmd && !new_word[pin_test_pkg::fuse_vpp_bit]
        |=> pins_o.fuse_level == $past(new_word[pin_test_pkg::data_bit]
            | new_word[pin_test_pkg::fuse_lvl_bit]))
        else $error("shared pin level does not follow its bits");

    chk_test_level: assert property (
        word_wr && !end_cmd && new_word[pin_test_pkg::test_lvl_bit]
        |=> pins_o.test_level)
        else $error("test pin not raised by its level bit");

    chk_data_zero: assert property (
        word_wr && !end_cmd && !new_word[pin_test_pkg::data_bit]
        |=> pins_o.target_data_line == 8'h00)
        else $error("data line driven without the data bit");

    chk_byte_ignore: assert property (
        wr && wb_adr_i == pin_test_pkg::ctrl_off && wb_sel_i[1:0] == 2'b00
        |=> $stable(word_q) && $stable(pins_o))
        else $error("control write with no byte lanes changed the word");

    // Every change on the connector must stem from one applied word, never from two steps.
    chk_pins_atomic: assert property (
        !$past(rst_i) && $changed(pins_o) |-> $past(word_wr))
        else $error("pins changed in a cycle with no word applied");

    chk_read_hold: assert property (
        !rd |=> $stable(wb_dat_o))
        else $error("read data changed without a read");

    // Main scenarios that the bench is expected to reach.
    cov_word_applied: cover property (word_wr && !end_cmd ##1 pins_o.fuse_vpp);
    cov_end_check:    cover property (end_cmd);
    cov_gang_done:    cover property (busy_q ##1 !busy_q ##[1:20] irq_o);
    cov_partial_word: cover property (word_wr && wb_sel_i[1:0] != 2'b11);
    cov_fuse_forced:  cover property (word_wr && new_word[9] && new_word[7]);

endmodule // target_pin_test_driver

// ==== pin_test_pkg.sv ====
// Package with register map, control word layout, codes and pin types of the pin test driver.
package pin_test_pkg;

    // Register byte offsets on the Wishbone slave.
    localparam logic [3:0] ctrl_off     = 4'h0;
    localparam logic [3:0] result_off   = 4'h4;
    localparam logic [3:0] irq_stat_off = 4'h8;
    localparam logic [3:0] irq_mask_off = 4'hc;

    // Pin control word field positions.
    localparam int sel_lsb      = 0;
    localparam int sel_width    = 3;
    localparam int data_bit     = 3;
    localparam int tck_bit      = 4;
    localparam int tms_bit      = 5;
    localparam int test_lvl_bit = 6;
    localparam int fuse_lvl_bit = 7;
    localparam int supply_bit   = 8;
    localparam int fuse_vpp_bit = 9;
    localparam int test_vpp_bit = 10;
    localparam int end_bit      = 15;

    localparam logic [15:0] reserved_mask = 16'h7800;
    localparam logic [15:0] end_of_check  = 16'h8000;
    localparam logic [15:0] ctrl_reset    = 16'h0000;

    // Result register field positions.
    localparam int result_lsb = 0;
    localparam int error_lsb  = 8;
    localparam int busy_bit   = 16;

    // General error codes.
    localparam logic [7:0] err_none       = 8'h00;
    localparam logic [7:0] err_image      = 8'h01;
    localparam logic [7:0] err_no_params  = 8'h0b;
    localparam logic [7:0] err_no_voltage = 8'h10;

    // Interrupt status and mask bit positions.
    localparam int irq_word_bit = 0;
    localparam int irq_end_bit  = 1;
    localparam int irq_done_bit = 2;
    localparam int irq_width    = 3;

    typedef struct packed {
        logic [7:0] target_data_line;
        logic       fuse_level;
        logic       fuse_vpp;
        logic       test_level;
        logic       test_vpp;
        logic       tck;
        logic       tms;
        logic       target_supply_output;
    } pins_type;

    localparam pins_type pins_reset = '0;

endpackage

// ==== gang_engine_model.sv ====
// Behavioural model of the programming engine and targets that feed the gang status inputs.
`timescale 1ns/1ps
module gang_engine_model (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       start_i,
    input  wire logic [7:0] len_i,
    input  wire logic [7:0] ok_i,
    input  wire logic [7:0] err_i,
    output logic            busy_o,
    output logic [7:0]      channel_ok_o,
    output logic [7:0]      error_code_o
);
    logic [7:0] cnt_q;
    logic       hold_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_o <= 1'h0;
            cnt_q  <= 8'h00;
            hold_q <= 1'h0;
        end else if (start_i) begin
            busy_o <= 1'h1;
            cnt_q  <= len_i;
        end else if (busy_o) begin
            cnt_q <= cnt_q - 8'h01;
            if (cnt_q == 8'h00) begin
                busy_o <= 1'h0;
                hold_q <= 1'h1;
            end
        end else begin
            hold_q <= 1'h0;
        end
    end

    // Results are only valid through the cycle after busy falls; afterwards they show garbage.
    assign channel_ok_o = (busy_o || hold_q) ? ok_i : ~ok_i;
    assign error_code_o = (busy_o || hold_q) ? err_i : ~err_i;
endmodule // gang_engine_model

// ==== target_pin_test_driver_tb.sv ====
// Self-checking testbench of the pin test driver.
`timescale 1ns/1ps
module target_pin_test_driver_tb;
    logic                   clk_i = 1'h0;
    logic                   rst_i = 1'h1;
    logic                   wb_cyc = 1'h0, wb_stb = 1'h0, wb_we = 1'h0, wb_ack, irq;
    logic [3:0]             wb_adr = 4'h0, wb_sel = 4'h0, wsel = 4'hf;
    logic [31:0]            wb_dat = 32'h0, wb_dat_o, rd;
    logic                   start = 1'h0, busy;
    logic [7:0]             len = 8'h00, ok = 8'h00, err = 8'h00, ch_ok, ch_err;
    pin_test_pkg::pins_type pins;
    int                     fails = 0, checks = 0;
    logic [15:0]            words [10] = '{16'h0005, 16'h0010, 16'h0020, 16'h0040, 16'h0080,
                                           16'h0100, 16'h0200, 16'h0280, 16'h0400, 16'h040a};
    logic [7:0]             codes [4] = '{8'h00, 8'h01, 8'h0b, 8'h10};

    target_pin_test_driver dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
        .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack), .gang_busy_i(busy),
        .channel_ok_i(ch_ok), .error_code_i(ch_err), .pins_o(pins), .irq_o(irq));
    gang_engine_model engine (.clk_i(clk_i), .rst_i(rst_i), .start_i(start), .len_i(len),
        .ok_i(ok), .err_i(err), .busy_o(busy), .channel_ok_o(ch_ok), .error_code_o(ch_err));

    initial begin
        forever #12.5 clk_i = ~clk_i;
    end

    function automatic pin_test_pkg::pins_type exp_pins(input logic [15:0] w);
        pin_test_pkg::pins_type p;
        p = '0;
        if (!w[15]) begin
            p.target_data_line = w[3] ? (8'h01 << w[2:0]) : 8'h00;
            p.fuse_level = !w[9] && (w[3] || w[7]);
            p.fuse_vpp = w[9];
            p.test_level = w[6];
            p.test_vpp = w[10];
            p.tck = w[4];
            p.tms = w[5];
            p.target_supply_output = w[8];
        end
        return p;
    endfunction

    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc <= 1'h1;
        wb_stb <= 1'h1;
        wb_we  <= w;
        wb_adr <= a;
        wb_dat <= d;
        wb_sel <= wsel;
        do begin
            @(posedge clk_i);
        end while (wb_ack !== 1'h1);
        rd = wb_dat_o;
        wb_cyc <= 1'h0;
        wb_stb <= 1'h0;
        @(posedge clk_i);
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic rdchk(input string nm, input logic [3:0] a, input logic [31:0] e);
        wb(1'h0, a, 32'h0);
        chk(nm, e, rd);
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        repeat (4000) @(posedge clk_i);
        fails++;
        stop_test();
    end

    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'h0;
        chk("pins", 32'h0, 32'(pins));
        for (int a = 0; a < 16; a += 4) rdchk("reset reg", 4'(a), 32'h0);
        $display("test reset done");
        for (int c = 0; c < 8; c++) begin
            wb(1'h1, pin_test_pkg::ctrl_off, 32'h8 | c);
            chk("pins sel", 32'(exp_pins(16'(c) | 16'h0008)), 32'(pins));
        end
        foreach (words[i]) begin
            wb(1'h1, pin_test_pkg::ctrl_off, 32'(words[i]));
            chk("pins bit", 32'(exp_pins(words[i])), 32'(pins));
        end
        repeat (10) @(posedge clk_i);
        chk("pins hold", 32'(exp_pins(16'h040a)), 32'(pins));
        rdchk("ctrl", pin_test_pkg::ctrl_off, 32'h040a);
        wsel = 4'h1;
        wb(1'h1, pin_test_pkg::ctrl_off, 32'h0000_0010);
        chk("pins low byte", 32'(exp_pins(16'h0410)), 32'(pins));
        wsel = 4'h2;
        wb(1'h1, pin_test_pkg::ctrl_off, 32'h0000_0200);
        chk("pins high byte", 32'(exp_pins(16'h0210)), 32'(pins));
        wsel = 4'h4;
        wb(1'h1, pin_test_pkg::ctrl_off, 32'h00ff_ffff);
        chk("pins no byte", 32'(exp_pins(16'h0210)), 32'(pins));
        wsel = 4'hf;
        $display("test pins done");
        wb(1'h1, pin_test_pkg::irq_mask_off, 32'h1);
        chk("irq set", 32'h1, 32'(irq));
        rdchk("irq stat", pin_test_pkg::irq_stat_off, 32'h1);
        chk("irq clear", 32'h0, 32'(irq));
        wb(1'h1, pin_test_pkg::irq_mask_off, 32'h4);
        wb(1'h1, pin_test_pkg::ctrl_off, 32'h0010);
        chk("irq masked", 32'h0, 32'(irq));
        rdchk("irq stat", pin_test_pkg::irq_stat_off, 32'h1);
        $display("test irq done");
        foreach (codes[i]) begin
            @(posedge clk_i);
            ok <= 8'hef ^ 8'(i);
            err <= codes[i];
            len <= 8'(i * 12);
            start <= 1'h1;
            @(posedge clk_i);
            start <= 1'h0;
            if (i > 0) begin
                wb(1'h0, pin_test_pkg::result_off, 32'h0);
                chk("busy", 32'h1, 32'(rd[16]));
            end
            while (busy !== 1'h0) @(posedge clk_i);
            repeat (3) @(posedge clk_i);
            rdchk("result", pin_test_pkg::result_off, {16'h0, codes[i], 8'hef ^ 8'(i)});
            if (rd[15:8] != 8'h00) $display("run %0d results void, error %0d", i, rd[15:8]);
            chk("irq done", 32'h1, 32'(irq));
            rdchk("irq stat", pin_test_pkg::irq_stat_off, 32'h4);
        end
        $display("test gang done");
        wb(1'h1, pin_test_pkg::ctrl_off, 32'h07ff);
        wb(1'h1, pin_test_pkg::ctrl_off, 32'h8000);
        repeat (2) @(posedge clk_i);
        chk("pins end", 32'h0, 32'(pins));
        rdchk("ctrl end", pin_test_pkg::ctrl_off, 32'h0);
        rdchk("result end", pin_test_pkg::result_off, 32'h0);
        wb(1'h0, pin_test_pkg::irq_stat_off, 32'h0);
        chk("irq end bit", 32'h1, 32'(rd[1]));
        rdchk("mask kept", pin_test_pkg::irq_mask_off, 32'h4);
        rdchk("unmapped", 4'h6, 32'h0);
        $display("test end done");
        stop_test();
    end
endmodule // target_pin_test_driver_tb
